/* core/asrhc_pkg.sv */
// Package of constants for the asynchronous 4K x 4 SRAM host controller
//==========================================================================
// Summary of operation
// - Host keeps select or strobe high while address lines change.
// - Host holds address stable across the whole write, zero setup and hold.
// - Write starts on later falling edge, ends on earlier rising edge.
// - Host drives write data setup time before write end, holds past it.
// - Host meets address, select and strobe minimum times before write end.
// - Host deselects before supply falls, waits a read period after recovery; code deselects only once I_SUPPLY_LOW is seen and any access ends.
//==========================================================================
package asrhc_pkg;
    // Clock period in picoseconds (125 MHz)
    localparam int CLK_PS = 8000;
    // Memory geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 4;
    // Timing figures of the slowest grade, in ns
    localparam int ADDR_TO_DATA_DELAY_NS = 45;
    localparam int READ_PERIOD_NS = 45;
    localparam int ADDR_BEFORE_WRITE_END_NS = 40;
    localparam int SELECT_BEFORE_WRITE_END_NS = 40;
    localparam int STROBE_BEFORE_WRITE_END_NS = 40;
    localparam int DIN_SETUP_NS = 18;
    localparam int STROBE_TO_HIZ_DELAY_NS = 17;
    // Least times and longest times both round up, never below one cycle
    localparam int RD_CYC = (ADDR_TO_DATA_DELAY_NS * 1000 + CLK_PS - 1)
        / CLK_PS + 1;
    localparam int WR_LOW_NS = (STROBE_BEFORE_WRITE_END_NS
        > SELECT_BEFORE_WRITE_END_NS) ? STROBE_BEFORE_WRITE_END_NS
        : SELECT_BEFORE_WRITE_END_NS;
    localparam int WR_CYC = (WR_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int HIZ_CYC = (STROBE_TO_HIZ_DELAY_NS * 1000 + CLK_PS - 1)
        / CLK_PS;
    localparam int REC_CYC = (READ_PERIOD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // Data must stand this many cycles on the pins before the strobe rises
    localparam int DS_CYC = (DIN_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // Strobe low time is the longer of the width and the float plus setup
    localparam int WR_END_CYC = (WR_CYC > HIZ_CYC + DS_CYC) ? WR_CYC
        : HIZ_CYC + DS_CYC;
    localparam int CNT_W = 4;
endpackage

/* core/asrhc_pins_if.sv */
// Interface carrying the SRAM pin group between host modules
`timescale 1ns/100ps
interface asrhc_pins_if;
    import asrhc_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic select_n;
    logic strobe_n;
    logic [DATA_W-1:0] dout;
    logic dout_oe;
    logic [DATA_W-1:0] din;
    modport drv (output addr, select_n, strobe_n, dout, dout_oe, input din);
    modport pad (input addr, select_n, strobe_n, dout, dout_oe, output din);
endinterface

/* core/asrhc_pad.sv */
// Pin stage: registers the data bus sampled from the memory
`timescale 1ns/100ps
module asrhc_pad
    import asrhc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Pins from memory
    input wire logic [DATA_W-1:0] i_nibble_io,
    // Pin group toward controller
    asrhc_pins_if.pad pins
);
    // Register read data so the capture point is a flip-flop
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            pins.din <= '0;
        else
            pins.din <= i_nibble_io;
    end
endmodule // asrhc_pad

/* core/asrhc_ctrl.sv */
// Top: host controller driving an asynchronous 4K x 4 SRAM
`timescale 1ns/100ps
module asrhc_ctrl
    import asrhc_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    // Request port
    input wire logic I_REQ_VALID,
    input wire logic I_REQ_WRITE,
    input wire logic [ADDR_W-1:0] I_REQ_ADDR,
    input wire logic [DATA_W-1:0] I_REQ_WDATA,
    output logic O_REQ_READY,
    output logic O_RD_VALID,
    output logic [DATA_W-1:0] O_RD_DATA,
    // Retention control
    input wire logic I_SUPPLY_LOW,
    // Memory pins
    output logic [ADDR_W-1:0] O_WORD_ADDR_LINES,
    output logic O_SELECT_N,
    output logic O_STROBE_N,
    input wire logic [DATA_W-1:0] I_NIBBLE_IO,
    output logic [DATA_W-1:0] O_NIBBLE_IO,
    output logic O_NIBBLE_IO_OE
);
    //======================================================================
    // State
    //======================================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD = 3'b001,
        ST_WHIZ = 3'b010,
        ST_WR = 3'b011,
        ST_WEND = 3'b100,
        ST_RET = 3'b101,
        ST_REC = 3'b110
    } asrhc_state_e;

    typedef struct packed {
        asrhc_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic select_n;
        logic strobe_n;
        logic oe;
        logic rd_valid;
        logic [DATA_W-1:0] rd_data;
    } asrhc_state_s;

    asrhc_state_s r;
    asrhc_state_s next_r;
    asrhc_pins_if pins ();

    localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_CYC - 1);
    // Counted from strobe fall, so the data setup after the float fits too
    localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_END_CYC - 1);
    localparam logic [CNT_W-1:0] HIZ_LAST = CNT_W'(HIZ_CYC - 1);
    localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(REC_CYC - 1);

    // Registered read data capture stage
    asrhc_pad u_pad (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_nibble_io(I_NIBBLE_IO),
        .pins(pins)
    );

    //======================================================================
    // Next-state logic
    //======================================================================
    // Memory needs no clock; every access and recovery phase is paced by cycle counts
    always_comb
    begin
        next_r = r;
        next_r.rd_valid = 1'b0;
        next_r.cnt = r.cnt + 1'b1;
        case (r.st)
            ST_IDLE:
            begin
                next_r.cnt = '0;
                next_r.select_n = 1'b1;
                next_r.strobe_n = 1'b1;
                next_r.oe = 1'b0;
                if (I_SUPPLY_LOW)
                    next_r.st = ST_RET;
                else if (I_REQ_VALID)
                begin
                    // Address moves only while select is high
                    next_r.addr = I_REQ_ADDR;
                    next_r.wdata = I_REQ_WDATA;
                    next_r.select_n = 1'b0;
                    if (I_REQ_WRITE)
                    begin
                        // Strobe low with select: write window opens
                        next_r.strobe_n = 1'b0;
                        next_r.st = ST_WHIZ;
                    end
                    else
                        next_r.st = ST_RD;
                end
            end
            ST_RD:
            begin
                // Bus released while memory drives; wait full access time
                next_r.oe = 1'b0;
                if (r.cnt == RD_LAST)
                begin
                    next_r.rd_valid = 1'b1;
                    next_r.rd_data = pins.din;
                    next_r.select_n = 1'b1;
                    next_r.st = ST_IDLE;
                end
            end
            ST_WHIZ:
            begin
                // Let the memory float its pins before we drive
                if (r.cnt == HIZ_LAST)
                begin
                    next_r.oe = 1'b1;
                    next_r.cnt = CNT_W'(HIZ_CYC);
                    next_r.st = ST_WR;
                end
            end
            ST_WR:
            begin
                // Hold strobe, select, address and data for minimum widths
                if (r.cnt == WR_LAST)
                begin
                    next_r.strobe_n = 1'b1;
                    next_r.st = ST_WEND;
                end
            end
            ST_WEND:
            begin
                // Data and address held one cycle past the strobe rise
                next_r.select_n = 1'b1;
                next_r.oe = 1'b0;
                next_r.st = ST_IDLE;
            end
            ST_RET:
            begin
                // Deselected for the rest of the low-supply period once any access under way ends
                next_r.cnt = '0;
                next_r.select_n = 1'b1;
                next_r.strobe_n = 1'b1;
                next_r.oe = 1'b0;
                if (!I_SUPPLY_LOW)
                    next_r.st = ST_REC;
            end
            ST_REC:
            begin
                if (I_SUPPLY_LOW)
                    next_r.st = ST_RET;
                else if (r.cnt == REC_LAST)
                    next_r.st = ST_IDLE;
            end
            default:
                next_r.st = ST_IDLE;
        endcase
    end

    // Single register bank for all state
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RESET)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.select_n <= 1'b1;
            r.strobe_n <= 1'b1;
        end
        else
            r <= next_r;
    end

    //======================================================================
    // Outputs
    //======================================================================
    // Pins come straight from flip-flops to avoid glitches on the strobes
    assign pins.addr = r.addr;
    assign pins.select_n = r.select_n;
    assign pins.strobe_n = r.strobe_n;
    assign pins.dout = r.wdata;
    assign pins.dout_oe = r.oe;
    assign O_WORD_ADDR_LINES = pins.addr;
    assign O_SELECT_N = pins.select_n;
    assign O_STROBE_N = pins.strobe_n;
    assign O_NIBBLE_IO = pins.dout;
    assign O_NIBBLE_IO_OE = pins.dout_oe;
    assign O_REQ_READY = (r.st == ST_IDLE) && !I_SUPPLY_LOW;
    assign O_RD_VALID = r.rd_valid;
    assign O_RD_DATA = r.rd_data;
endmodule // asrhc_ctrl

/* sim/asrhc_sram_model.sv */
// Behavioural 4K x 4 asynchronous SRAM on the far side
`timescale 1ns/100ps
module asrhc_sram_model
    import asrhc_pkg::*;
#(
    parameter int ACC_NS = 45
)
(
    // Pins from the host
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_sel_n,
    input wire logic i_stb_n,
    input wire logic [DATA_W-1:0] i_hd,
    input wire logic i_hoe,
    // Resolved data wire
    output logic [DATA_W-1:0] o_dq
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] last = 4'h0;
    logic [7:0] seq = 8'h00;
    logic [7:0] seq_d;
    // No clock here: all from pin levels
    wire rd = !i_sel_n && i_stb_n;
    wire wr = !i_sel_n && !i_stb_n;
    wire ok = rd && (seq_d == seq);
    // Any address, select or strobe move restarts the access time
    always @(i_addr or i_sel_n or i_stb_n) seq = seq + 8'h01;
    assign #(ACC_NS) seq_d = seq;
    // Store when the write ends on either rising edge
    always @(negedge wr) mem[i_addr] = i_hd;
    always @(posedge ok) last = mem[i_addr];
    // Released or unsettled pins show the inverse, not a stale copy
    assign o_dq = i_hoe ? i_hd : ok ? mem[i_addr] : ~last;
endmodule // asrhc_sram_model

/* sim/asrhc_ctrl_assertions.sv */
// Pin timing checker of the SRAM host controller
`timescale 1ns/100ps
module asrhc_ctrl_assertions
    import asrhc_pkg::*;
(
    // Watched ports
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic I_REQ_VALID,
    input wire logic I_REQ_WRITE,
    input wire logic O_REQ_READY,
    input wire logic O_RD_VALID,
    input wire logic I_SUPPLY_LOW,
    input wire logic [ADDR_W-1:0] O_WORD_ADDR_LINES,
    input wire logic O_SELECT_N,
    input wire logic O_STROBE_N,
    input wire logic [DATA_W-1:0] O_NIBBLE_IO,
    input wire logic O_NIBBLE_IO_OE
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    wire take = I_REQ_VALID && O_REQ_READY;
    // Select held through the whole access time
    sequence rd_wait;
        !O_SELECT_N [*7];
    endsequence
    // Strobe low six cycles, write ends on strobe first
    sequence wr_pulse;
        (!O_SELECT_N && !O_STROBE_N) [*6] ##1 (O_STROBE_N && !O_SELECT_N);
    endsequence
    take_select_a: assert property (
        take |=> !O_SELECT_N && !O_REQ_READY)
        else $error("Select missing after request");
    read_answer_a: assert property (
        take && !I_REQ_WRITE |=> rd_wait ##[0:2] O_RD_VALID)
        else $error("Read access too short");
    write_pulse_a: assert property (
        take && I_REQ_WRITE |=> wr_pulse)
        else $error("Write pulse wrong");
    addr_hold_a: assert property (
        !O_SELECT_N && !$past(O_SELECT_N) |-> $stable(O_WORD_ADDR_LINES))
        else $error("Address moved while selected");
    strobe_inside_a: assert property (
        !O_STROBE_N |-> !O_SELECT_N)
        else $error("Strobe low while deselected");
    host_release_a: assert property (
        O_NIBBLE_IO_OE |-> !O_SELECT_N && !$past(O_STROBE_N))
        else $error("Host drives outside a write");
    hiz_wait_a: assert property (
        $rose(O_NIBBLE_IO_OE) |-> $past(!O_STROBE_N, 2))
        else $error("Host drove before memory floated");
    din_setup_a: assert property (
        $rose(O_STROBE_N) |-> O_NIBBLE_IO_OE && $stable(O_NIBBLE_IO)
            && $past(O_NIBBLE_IO_OE, 3))
        else $error("Write data setup or hold broken");
    recovery_a: assert property (
        $fell(I_SUPPLY_LOW) |-> !O_REQ_READY [*5])
        else $error("Ready too soon after supply return");
endmodule // asrhc_ctrl_assertions

bind asrhc_ctrl asrhc_ctrl_assertions i_asrhc_ctrl_assertions (
    .I_CLK_SYS, .I_RESET, .I_REQ_VALID, .I_REQ_WRITE, .O_REQ_READY,
    .O_RD_VALID, .I_SUPPLY_LOW, .O_WORD_ADDR_LINES, .O_SELECT_N,
    .O_STROBE_N, .O_NIBBLE_IO, .O_NIBBLE_IO_OE);

/* sim/asrhc_ctrl_test.sv */
// Testbench of the SRAM host controller
`timescale 1ns/100ps
module asrhc_ctrl_test;
    import asrhc_pkg::*;
    logic clk = 0, rst = 1, vld = 0, wr = 0, lo = 0;
    logic [ADDR_W-1:0] adr = 12'h000, pa;
    logic [DATA_W-1:0] wd = 4'h0, rd, dq, hd;
    logic rdy, rv, sn, wn, oe;
    int num_errors = 0, compares = 0, cyc = 0;
    asrhc_ctrl i_asrhc_ctrl (.I_CLK_SYS(clk), .I_RESET(rst),
        .I_REQ_VALID(vld), .I_REQ_WRITE(wr), .I_REQ_ADDR(adr),
        .I_REQ_WDATA(wd), .O_REQ_READY(rdy), .O_RD_VALID(rv),
        .O_RD_DATA(rd), .I_SUPPLY_LOW(lo), .O_WORD_ADDR_LINES(pa),
        .O_SELECT_N(sn), .O_STROBE_N(wn), .I_NIBBLE_IO(dq),
        .O_NIBBLE_IO(hd), .O_NIBBLE_IO_OE(oe));
    asrhc_sram_model i_asrhc_sram_model (.i_addr(pa), .i_sel_n(sn),
        .i_stb_n(wn), .i_hd(hd), .i_hoe(oe), .o_dq(dq));
    // Clock and hang guard; a full run needs about 100 cycles
    initial forever #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            results();
        end
    end
    task automatic check(input logic [7:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Request held until the edge that sees ready
    task automatic req(input logic w, input logic [11:0] a, logic [3:0] d);
        // Start on a fresh edge so valid is never set twice in one step
        @(posedge clk);
        vld <= 1'b1;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        vld <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [3:0] e);
        req(1'b0, a, 4'h0);
        do @(posedge clk); while (rv !== 1'b1);
        check(rd, e);
    endtask
    task automatic t_idle();
        check({sn, wn, oe, rdy}, 8'h0D);
    endtask
    // Back-to-back writes at both address ends and the middle, then reads
    task automatic t_rw();
        req(1'b1, 12'h000, 4'h5);
        req(1'b1, 12'hFFF, 4'hA);
        req(1'b1, 12'h800, 4'h3);
        rd_chk(12'h000, 4'h5);
        rd_chk(12'hFFF, 4'hA);
        rd_chk(12'h800, 4'h3);
        req(1'b1, 12'hFFF, 4'hC);
        rd_chk(12'hFFF, 4'hC);
    endtask
    // Retention: no request served until recovery, data kept
    task automatic t_ret();
        lo <= 1'b1;
        repeat (3) @(posedge clk);
        check({sn, rdy}, 8'h02);
        lo <= 1'b0;
        @(posedge clk);
        #1 check(rdy, 8'h00);
        rd_chk(12'h800, 4'h3);
    endtask
    task automatic results();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 t_idle();
        t_rw();
        t_ret();
        results();
    end
endmodule // asrhc_ctrl_test
